// File: row_select_pkg.sv
// Functional notes
// R1 - The driver has 32 channels, each one driving one sensor row.
// R2 - Every channel owns a clear switch and a gate switch for its row.
// R3 - Gate enable drives the row negative; clear enable drives it positive.
// R4 - A shift register spanning all channels advances the selection in sequence.
// R5 - The sequencer loads exactly one set bit into the chain input.
// R6 - Each shift clock moves the set bit to the next channel.
// R7 - Chain output feeds the chain input of a following device.
// R8 - Gate and clear switches fire only by strobes, never by selection alone.
// R9 - Strobe timing gives non-overlapping, overlapping, row-skip and gated operation.
// R10 - In gated operation all channels' clear outputs are enabled; the code skips gate-active rows, which clear only on the strobe.
// R11 - Entering gated operation, clears turn on in four successive groups.
// R12 - A row boosts before its selection and sleeps after the next is selected.
// R13 - Each set bit wakes its own channel and both neighbours.
// R14 - At power-up the sequencer flushes the shift register with zeros first.
// R15 - Input termination stays off until enabled by configuration.
// R16 - A clear pulse acts only while the row gate is active and CLK high.
// R17 - Gated enable is applied sequentially to groups of 8 channels.
// R18 - Non-overlapping: current gate switches off as the next gate switches on.
// R19 - Termination enable sits in configuration bits 2:0.
// R20 - Chain output presents the bit shifted out of the last channel.
// R21 - After a zero flush nothing is selected, all sleep, no gate fires.
package row_select_pkg;
   localparam int NUM_CH = 32;
   localparam int GRP_SIZE = 8;
   localparam int NUM_GRP = 4;
   localparam int GRP_CNT_W = 3;
   localparam int TERM_CFG_W = 3;
   localparam logic [GRP_CNT_W-1:0] GRP_CNT_RST = 3'h0;
   localparam logic [GRP_CNT_W-1:0] GRP_CNT_FULL = 3'h4;
   localparam logic SEL_RST = 1'h0;
   localparam logic TERM_RST = 1'h0;
endpackage

// File: row_select_shift_driver.sv
`timescale 1ns/1ps
module row_select_shift_driver #(
   parameter int N_CH = row_select_pkg::NUM_CH,
   parameter int G_SIZE = row_select_pkg::GRP_SIZE
)(
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_shift_clk,
   input wire logic i_chain_in,
   input wire logic i_gate_strobe,
   input wire logic i_clear_strobe,
   input wire logic [row_select_pkg::TERM_CFG_W-1:0] i_term_cfg,
   output logic o_chain_out,
   output logic [N_CH-1:0] o_gate_on,
   output logic [N_CH-1:0] o_clear_on,
   output logic [N_CH-1:0] o_boost,
   output logic o_term_en
);
   localparam int CW = row_select_pkg::GRP_CNT_W;

   // Previous samples for edge detection
   logic shift_clk_prev_q;
   logic gate_strobe_prev_q;
   logic shift_rise;
   logic shift_fall;
   logic gstrb_rise;
   logic gstrb_fall;

   // Token chain and per-row state
   logic [N_CH-1:0] sel_q;
   logic [N_CH-1:0] sel_d;
   logic chain_out_q;
   logic chain_out_d;
   logic [N_CH-1:0] row_gate_active_q;
   logic [N_CH-1:0] row_gate_active_d;
   logic [N_CH-1:0] clear_q;
   logic [N_CH-1:0] clear_d;
   logic [N_CH-1:0] boost_q;
   logic [N_CH-1:0] boost_d;
   logic [N_CH+1:0] wake_ext;
   logic [N_CH-1:0] grp_mask;

   // Gated operation state
   logic gated_q;
   logic gated_d;
   logic [CW-1:0] grp_cnt_q;
   logic [CW-1:0] grp_cnt_d;
   logic term_q;
   logic term_d;

   assign shift_rise = i_shift_clk & ~shift_clk_prev_q;
   assign shift_fall = ~i_shift_clk & shift_clk_prev_q;
   assign gstrb_rise = i_gate_strobe & ~gate_strobe_prev_q;
   assign gstrb_fall = ~i_gate_strobe & gate_strobe_prev_q;

   // Selection token and gate states
   always_comb
   begin
      sel_d = sel_q;
      chain_out_d = chain_out_q;
      row_gate_active_d = row_gate_active_q;
      if (shift_rise)
      begin
         sel_d = {sel_q[N_CH-2:0], i_chain_in}; // R4 R6
         chain_out_d = sel_q[N_CH-1]; // R7 R20
      end
      // Falling CLK ends gates of rows that lost the token
      if (shift_fall)
      begin
         row_gate_active_d = row_gate_active_q & sel_q; // R9
      end
      if (gstrb_rise)
      begin
         if (i_shift_clk)
         begin
            // Overlapping: new row joins before the old one drops
            row_gate_active_d = row_gate_active_d | sel_q; // R8 R9
         end
         else
         begin
            row_gate_active_d = sel_q; // R18 R8 R21
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         sel_q <= {N_CH{row_select_pkg::SEL_RST}};
         chain_out_q <= row_select_pkg::SEL_RST;
         row_gate_active_q <= {N_CH{row_select_pkg::SEL_RST}};
      end
      else
      begin
         sel_q <= sel_d;
         chain_out_q <= chain_out_d;
         row_gate_active_q <= row_gate_active_d;
      end
   end

   // Gated mode: sampled at falling gate strobe, groups enabled one per edge
   always_comb
   begin
      gated_d = gated_q;
      grp_cnt_d = grp_cnt_q;
      if (gstrb_fall)
      begin
         if (i_shift_clk | i_clear_strobe)
         begin
            gated_d = 1'b1;
            if (grp_cnt_q != row_select_pkg::GRP_CNT_FULL)
            begin
               grp_cnt_d = grp_cnt_q + 3'h1; // R11 R17
            end
         end
         else
         begin
            gated_d = 1'b0;
            grp_cnt_d = row_select_pkg::GRP_CNT_RST;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         gated_q <= 1'b0;
         grp_cnt_q <= row_select_pkg::GRP_CNT_RST;
      end
      else
      begin
         gated_q <= gated_d;
         grp_cnt_q <= grp_cnt_d;
      end
   end

   // Outputs: clear, boost, termination
   always_comb
   begin
      for (int i = 0; i < N_CH; i++)
      begin
         grp_mask[i] = (32'(grp_cnt_q) > (i / G_SIZE)); // R17
      end
      wake_ext = {1'b0, sel_q, i_chain_in};
      for (int i = 0; i < N_CH; i++)
      begin
         boost_d[i] = wake_ext[i] | wake_ext[i+1] | wake_ext[i+2]; // R12 R13
      end
      // Strobed clear on the gated row; gated groups clear idle rows
      clear_d = (row_gate_active_q & {N_CH{i_shift_clk & i_clear_strobe}}) // R16
         | (grp_mask & ~row_gate_active_q); // R10
      term_d = (i_term_cfg[0] & i_term_cfg[1]) | (i_term_cfg[0] & i_term_cfg[2])
         | (i_term_cfg[1] & i_term_cfg[2]); // R15 R19
   end

   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         shift_clk_prev_q <= 1'b0;
         gate_strobe_prev_q <= 1'b0;
         clear_q <= {N_CH{1'b0}};
         boost_q <= {N_CH{1'b0}};
         term_q <= row_select_pkg::TERM_RST;
      end
      else
      begin
         shift_clk_prev_q <= i_shift_clk;
         gate_strobe_prev_q <= i_gate_strobe;
         clear_q <= clear_d;
         boost_q <= boost_d;
         term_q <= term_d;
      end
   end

   assign o_chain_out = chain_out_q;
   assign o_gate_on = row_gate_active_q; // R1 R2 R3
   assign o_clear_on = clear_q; // R2 R3
   assign o_boost = boost_q;
   assign o_term_en = term_q;

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_resetn);

   a_chain_shift: assert property ( // R6
      shift_rise |=> sel_q == {$past(sel_q[N_CH-2:0]), $past(i_chain_in)})
      else $error("token did not shift");
   a_chain_tail: assert property ( // R20
      shift_rise |=> o_chain_out == $past(sel_q[N_CH-1]))
      else $error("chain output not last channel");
   a_gate_cause: assert property ( // R8
      (|(o_gate_on & ~$past(o_gate_on))) |-> $past(gstrb_rise))
      else $error("gate rose without strobe");
   a_gate_nonoverlap: assert property ( // R18
      gstrb_rise && !i_shift_clk |=> o_gate_on == $past(sel_q))
      else $error("old gate not replaced");
   a_gate_drop_fall: assert property ( // R9
      shift_fall && !gstrb_rise |=> (o_gate_on & ~$past(sel_q)) == '0)
      else $error("deselected gate stayed on");
   a_clear_needs_gate: assert property ( // R16
      grp_cnt_q == '0 |=> (o_clear_on & ~$past(o_gate_on)) == '0)
      else $error("clear without gate");
   a_group_step: assert property ( // R11
      grp_cnt_q != $past(grp_cnt_q) |->
         grp_cnt_q == '0 || grp_cnt_q == CW'($past(grp_cnt_q) + 3'h1))
      else $error("group jump");
   a_boost_wake: assert property ( // R13
      sel_q[5] |=> o_boost[6:4] == 3'h7)
      else $error("neighbours not woken");
   a_flush_idle: assert property ( // R21
      sel_q == '0 && o_gate_on == '0 && gstrb_rise |=> o_gate_on == '0)
      else $error("gate fired after flush");
   a_term_off: assert property ( // R15
      i_term_cfg == 3'h0 |=> !o_term_en)
      else $error("termination on");

   // Token and chain output move only on a shift clock rise
   a_chain_hold: assert property ( // R4
      !shift_rise |=> sel_q == $past(sel_q))
      else $error("token moved without shift");

   a_chain_entry: assert property ( // R4
      shift_rise && i_chain_in |=> sel_q[0])
      else $error("token not taken in");

   a_tail_hold: assert property ( // R7
      !shift_rise |=> o_chain_out == $past(o_chain_out))
      else $error("chain output changed without shift");

   // Boost window around the token
   a_boost_ahead: assert property ( // R12
      i_chain_in |=> o_boost[0])
      else $error("first row not boosted ahead");

   a_boost_own: assert property ( // R12
      sel_q[0] |=> o_boost[0] && o_boost[1])
      else $error("selected row not boosted");

   a_boost_last: assert property ( // R13
      sel_q[N_CH-1] |=> o_boost[N_CH-1] && o_boost[N_CH-2])
      else $error("last row neighbours asleep");

   a_boost_sleep: assert property ( // R12
      sel_q == '0 && !i_chain_in |=> o_boost == '0)
      else $error("row boosted without token");

   // Gate switching by strobe or falling shift clock only
   a_gate_quiet: assert property ( // R8
      !gstrb_rise && !shift_fall |=> o_gate_on == $past(o_gate_on))
      else $error("gate changed without event");

   a_gate_sel_only: assert property ( // R8
      gstrb_rise |=> (o_gate_on & ~$past(o_gate_on | sel_q)) == '0)
      else $error("unselected gate fired");

   a_gate_overlap: assert property ( // R9
      gstrb_rise && i_shift_clk |=> (o_gate_on & $past(sel_q)) == $past(sel_q))
      else $error("overlapping gate not added");

   a_gate_keep: assert property ( // R9
      gstrb_rise && i_shift_clk |=> (o_gate_on & $past(o_gate_on)) == $past(o_gate_on))
      else $error("old gate dropped early");

   // Gated operation entry, groups and exit
   a_gated_enter: assert property ( // R10
      gstrb_fall && i_clear_strobe |=> gated_q)
      else $error("gated mode not entered");

   a_gated_leave: assert property ( // R10
      gstrb_fall && !i_shift_clk && !i_clear_strobe |=> grp_cnt_q == '0)
      else $error("gated mode not left");

   a_group_max: assert property ( // R11
      grp_cnt_q <= row_select_pkg::GRP_CNT_FULL)
      else $error("group count overflow");

   a_group_first: assert property ( // R17
      grp_cnt_q == 3'h1 && o_gate_on == '0 |=>
         o_clear_on == {{(N_CH-G_SIZE){1'b0}}, {G_SIZE{1'b1}}})
      else $error("first group wrong");

   a_group_all: assert property ( // R10
      grp_cnt_q == row_select_pkg::GRP_CNT_FULL && o_gate_on == '0 |=> o_clear_on == '1)
      else $error("not all clears on");

   // Strobed clear
   a_clear_strobe: assert property ( // R16
      i_shift_clk && i_clear_strobe && o_gate_on[0] |=> o_clear_on[0])
      else $error("strobed clear missing");

   a_clear_no_clk: assert property ( // R16
      !i_shift_clk && grp_cnt_q == '0 |=> o_clear_on == '0)
      else $error("clear while shift clock low");

   // Termination vote
   a_term_on: assert property ( // R19
      i_term_cfg == 3'h7 |=> o_term_en)
      else $error("termination not enabled");

   a_term_vote: assert property ( // R15
      $onehot0(i_term_cfg) |=> !o_term_en)
      else $error("single vote enabled termination");

endmodule // row_select_shift_driver

// File: strobe_sequencer.sv
`timescale 1ns/1ps
module strobe_sequencer (
   input wire logic i_clk,
   output logic o_shift_clk,
   output logic o_chain_in,
   output logic o_gate_strobe,
   output logic o_clear_strobe
);
   initial {o_shift_clk, o_chain_in, o_gate_strobe, o_clear_strobe} = 4'h0;

   // Applies {shift clock, chain input, gate strobe, clear strobe} and lets outputs settle
   task automatic drive(input logic [3:0] v);
      @(posedge i_clk);
      #1;
      {o_shift_clk, o_chain_in, o_gate_strobe, o_clear_strobe} = v;
      repeat (4) @(posedge i_clk);
      #2;
   endtask

   // Clocks zeros through every stage before operation starts
   task automatic flush(input int n);
      for (int k = 0; k < 2 * n; k++)
      begin
         @(posedge i_clk);
         #1;
         {o_chain_in, o_gate_strobe, o_clear_strobe} = 3'h0;
         o_shift_clk = ~o_shift_clk;
      end
   endtask
endmodule // strobe_sequencer

// File: tb_top.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin bad_count++; \
   $display("wrong value at %0t: got %0h expected %0h", $time, got, exp); end end
module tb_top;
   typedef struct packed {
      logic [3:0] stim;
      logic [31:0] gate;
      logic [31:0] clr;
      logic [31:0] bst;
   } row_t;
   logic clk = 1'h0;
   logic resetn = 1'h0;
   logic [2:0] term_cfg;
   logic exp_term;
   logic shift_clk, chain_in, gate_strobe, clear_strobe, chain_out, term_en;
   logic [31:0] gate_on, clear_on, boost;
   int bad_count = 0;
   int checks_done = 0;
   // Stimulus is {shift clock, chain input, gate strobe, clear strobe}
   row_t rows [20] = '{'{4'hC, 32'h0, 32'h0, 32'h3}, '{4'h0, 32'h0, 32'h0, 32'h3},
      '{4'h2, 32'h1, 32'h0, 32'h3}, '{4'h0, 32'h1, 32'h0, 32'h3}, '{4'h8, 32'h1, 32'h0, 32'h7},
      '{4'h9, 32'h1, 32'h1, 32'h7}, '{4'h8, 32'h1, 32'h0, 32'h7}, '{4'h0, 32'h0, 32'h0, 32'h7},
      '{4'h2, 32'h2, 32'h0, 32'h7}, '{4'h0, 32'h2, 32'h0, 32'h7}, '{4'h8, 32'h2, 32'h0, 32'hE},
      '{4'hA, 32'h6, 32'h0, 32'hE}, '{4'h2, 32'h4, 32'h0, 32'hE}, '{4'h0, 32'h4, 32'h0, 32'hE},
      '{4'h8, 32'h4, 32'h0, 32'h1C}, '{4'h0, 32'h0, 32'h0, 32'h1C},
      '{4'h8, 32'h0, 32'h0, 32'h38}, '{4'h0, 32'h0, 32'h0, 32'h38},
      '{4'h2, 32'h10, 32'h0, 32'h38}, '{4'h0, 32'h10, 32'h0, 32'h38}};

   always #4 clk = ~clk;

   strobe_sequencer seq_u (.i_clk(clk), .o_shift_clk(shift_clk), .o_chain_in(chain_in),
      .o_gate_strobe(gate_strobe), .o_clear_strobe(clear_strobe));

   row_select_shift_driver dut_u (.i_clk(clk), .i_resetn(resetn), .i_shift_clk(shift_clk),
      .i_chain_in(chain_in), .i_gate_strobe(gate_strobe), .i_clear_strobe(clear_strobe),
      .i_term_cfg(term_cfg), .o_chain_out(chain_out), .o_gate_on(gate_on),
      .o_clear_on(clear_on), .o_boost(boost), .o_term_en(term_en));

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial
   begin
      repeat (20000) @(posedge clk);
      bad_count++;
      finish_test();
   end

   initial
   begin
      term_cfg = 3'h7;
      repeat (20) @(posedge clk);
      `CHK(term_en, 1'h0)
      `CHK(gate_on | clear_on | boost, 32'h0)
      #1;
      resetn = 1'h1;
      term_cfg = 3'h0;
      seq_u.flush(32);
      seq_u.drive(4'h2);
      seq_u.drive(4'h0);
      `CHK({gate_on, boost, chain_out}, 65'h0)
      $display("test reset and flush done");
      foreach (rows[i])
      begin
         seq_u.drive(rows[i].stim);
         `CHK(gate_on, rows[i].gate)
         `CHK(clear_on, rows[i].clr)
         `CHK(boost, rows[i].bst)
      end
      $display("test strobe modes done");
      seq_u.flush(32);
      seq_u.drive(4'hC);
      for (int k = 0; k < 31; k++)
      begin
         seq_u.drive(4'h0);
         seq_u.drive(4'h8);
      end
      `CHK({chain_out, boost[31:30]}, 3'h3)
      seq_u.drive(4'h0);
      seq_u.drive(4'h8);
      `CHK({chain_out, boost}, 33'h100000000)
      $display("test chain output done");
      seq_u.drive(4'h1);
      for (int k = 1; k <= 4; k++)
      begin
         seq_u.drive(4'h3);
         seq_u.drive(4'h1);
         `CHK(clear_on, 32'(64'hFFFFFFFF >> (32 - row_select_pkg::GRP_SIZE * k)))
      end
      `CHK(gate_on, 32'h0)
      seq_u.drive(4'h0);
      seq_u.drive(4'h2);
      seq_u.drive(4'h0);
      `CHK(clear_on, 32'h0)
      $display("test gated mode done");
      for (int v = 0; v < 8; v++)
      begin
         term_cfg = 3'(v);
         exp_term = (term_cfg[0] & term_cfg[1]) | (term_cfg[0] & term_cfg[2]);
         exp_term = exp_term | (term_cfg[1] & term_cfg[2]);
         repeat (3) @(posedge clk);
         #1;
         `CHK(term_en, exp_term)
      end
      $display("test termination done");
      finish_test();
   end
endmodule // tb_top
